/* hdl/plk_pkg.sv */
`default_nettype none
package plk_pkg;
	localparam int          PIX_W       = 8;
	localparam int          CHAN_W      = 6;
	localparam int          ENTRIES     = 256;
	localparam int          WORD_W      = 3 * CHAN_W;
	localparam logic [1:0]  RS_PTR_WR   = 2'h0;
	localparam logic [1:0]  RS_PALETTE  = 2'h1;
	localparam logic [1:0]  RS_MASK     = 2'h2;
	localparam logic [1:0]  RS_PTR_RD   = 2'h3;
	localparam logic [7:0]  MASK_RESET  = 8'h00FF;
	localparam logic [7:0]  PTR_RESET   = 8'h0000;
	localparam logic [5:0]  BLANK_LEVEL = 6'h0000;
	localparam int          RED_LSB     = 12;
	localparam int          GREEN_LSB   = 6;
	localparam int          BLUE_LSB    = 0;

	typedef enum logic [1:0] {
		PH_RED   = 2'b00,
		PH_GREEN = 2'b01,
		PH_BLUE  = 2'b10
	} plk_phase_t;
endpackage : plk_pkg
`default_nettype wire

/* hdl/plk_skid.sv */
`default_nettype none
// Two-entry buffer: output register plus one skid entry
module plk_skid #(
	parameter int W = 18
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic         skid_valid;
	logic [W-1:0] skid_data;
	wire          out_free = out_ready | ~out_valid;

	// Ready is a flop so the upstream stall path stays short
	assign in_ready = ~skid_valid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid  <= 1'b0;
			out_data   <= '0;
			skid_valid <= 1'b0;
			skid_data  <= '0;
		end else if (out_free) begin
			out_valid  <= skid_valid | in_valid;
			out_data   <= skid_valid ? skid_data : in_data;
			skid_valid <= 1'b0;
		end else if (in_valid && !skid_valid) begin
			skid_valid <= 1'b1;
			skid_data  <= in_data;
		end
	end
endmodule : plk_skid
`default_nettype wire

/* hdl/plk_top.sv */
`default_nettype none
// How it works
// - Latched blank low forces channels to blank
// - Blank sampled with pixel index each clock the output buffer is ready
// - Pixel index ignored while blank latched low
// - Pixel index captured every rising clock edge unless the output buffer stalls
// - Index selects one of 256 entries
// - Write data captured at write strobe rise
// - Register select picks pointer, palette or mask access
// - Eight-bit data bus driven only during reads
// - Internal pointer addresses palette for host
// - Select 00 ptr-write, 11 ptr-read, 01 RAM, 10 mask
// - Three writes, blue stores word, pointer increments
// - Three reads red green blue, then increment
// - Colors on bits 5:0, upper bits zero
module plk_top (
	input  wire logic                       SYS_CLK,
	input  wire logic                       RST,
	input  wire logic [plk_pkg::PIX_W-1:0]  PIXEL_INDEX,
	input  wire logic                       BLANK_N,
	output logic                            PIX_IN_READY,
	output logic [plk_pkg::CHAN_W-1:0]      RED,
	output logic [plk_pkg::CHAN_W-1:0]      GREEN,
	output logic [plk_pkg::CHAN_W-1:0]      BLUE,
	output logic                            PIX_VALID,
	input  wire logic                       PIX_READY,
	input  wire logic                       HOST_WR_N,
	input  wire logic                       HOST_RD_N,
	input  wire logic [1:0]                 HOST_REGISTER_SELECT,
	input  wire logic [7:0]                 HOST_DATA_BUS_I,
	output logic [7:0]                      HOST_DATA_BUS_O,
	output logic                            HOST_DATA_BUS_OE
);
	import plk_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Host strobe synchronisers
	logic [1:0]  wr_n_m, rd_n_m;
	logic        wr_n_s, wr_n_d, rd_n_s, rd_n_d;
	logic [1:0]  rs_m, rs_s;
	logic [7:0]  din_m, din_s;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			wr_n_m <= 2'h3;
			rd_n_m <= 2'h3;
			{wr_n_s, wr_n_d, rd_n_s, rd_n_d} <= 4'hF;
			rs_m   <= '0;
			rs_s   <= '0;
			din_m  <= '0;
			din_s  <= '0;
		end else begin
			wr_n_m <= {wr_n_m[0], HOST_WR_N};
			rd_n_m <= {rd_n_m[0], HOST_RD_N};
			wr_n_s <= wr_n_m[1];
			wr_n_d <= wr_n_s;
			rd_n_s <= rd_n_m[1];
			rd_n_d <= rd_n_s;
			rs_m   <= HOST_REGISTER_SELECT;
			rs_s   <= rs_m;
			din_m  <= HOST_DATA_BUS_I;
			din_s  <= din_m;
		end
	end

	// An edge of either strobe is ignored while the other strobe is low
	wire wr_rise = wr_n_s & ~wr_n_d & rd_n_s;
	wire rd_fall = ~rd_n_s & rd_n_d & wr_n_s;
	wire rd_rise = rd_n_s & ~rd_n_d & wr_n_s;

	////////////////////////////////////////////////////////////////////////
	// Pointer, phase, mask and palette storage
	logic [7:0]        palette_pointer;
	plk_phase_t        color_phase_count;
	logic [7:0]        pixel_mask;
	logic [5:0]        red_hold, green_hold;
	logic [WORD_W-1:0] palette [ENTRIES];
	logic              rd_is_color;

	function automatic logic [5:0] chan_of(input logic [WORD_W-1:0] w, input plk_phase_t ph);
		case (ph)
			PH_RED:   chan_of = w[RED_LSB +: CHAN_W];
			PH_GREEN: chan_of = w[GREEN_LSB +: CHAN_W];
			default:  chan_of = w[BLUE_LSB +: CHAN_W];
		endcase
	endfunction : chan_of

	wire              sel_ptr_wr  = rs_s == RS_PTR_WR;
	wire              sel_palette = rs_s == RS_PALETTE;
	wire              sel_mask    = rs_s == RS_MASK;
	wire              sel_ptr_rd  = rs_s == RS_PTR_RD;
	wire              is_blue     = color_phase_count == PH_BLUE;
	wire              color_step  = sel_palette & (wr_rise | (rd_rise & rd_is_color));
	wire [7:0]        next_pointer = palette_pointer + 8'h01;          // FFh wraps to 00h
	wire [WORD_W-1:0] ptr_word    = palette[palette_pointer];
	wire [5:0]        ptr_chan    = chan_of(ptr_word, color_phase_count);

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			palette_pointer   <= PTR_RESET;
			color_phase_count <= PH_RED;
			pixel_mask        <= MASK_RESET;
			red_hold          <= '0;
			green_hold        <= '0;
		end else begin
			if (wr_rise && sel_ptr_wr) begin
				palette_pointer   <= din_s;
				color_phase_count <= PH_RED;
			end else if (color_step) begin
				case (color_phase_count)
					PH_RED:   color_phase_count <= PH_GREEN;
					PH_GREEN: color_phase_count <= PH_BLUE;
					default: begin
						color_phase_count <= PH_RED;
						palette_pointer   <= next_pointer;
					end
				endcase
			end
			if (wr_rise && sel_mask)
				pixel_mask <= din_s;
			if (wr_rise && sel_palette && color_phase_count == PH_RED)
				red_hold <= din_s[5:0];
			if (wr_rise && sel_palette && color_phase_count == PH_GREEN)
				green_hold <= din_s[5:0];
		end
	end

	// Palette is plain storage, no reset, written on the blue cycle
	always_ff @(posedge SYS_CLK) begin
		if (wr_rise && sel_palette && is_blue)
			palette[palette_pointer] <= {red_hold, green_hold, din_s[5:0]};
	end

	////////////////////////////////////////////////////////////////////////
	// Host read path
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			HOST_DATA_BUS_O  <= '0;
			HOST_DATA_BUS_OE <= 1'b0;
			rd_is_color      <= 1'b0;
		end else begin
			HOST_DATA_BUS_OE <= ~rd_n_s & wr_n_s;
			if (rd_fall) begin
				rd_is_color <= sel_palette;
				if (sel_ptr_rd)
					HOST_DATA_BUS_O <= palette_pointer;
				else if (sel_mask)
					HOST_DATA_BUS_O <= pixel_mask;
				else if (sel_palette)
					HOST_DATA_BUS_O <= {2'b00, ptr_chan};
				else
					HOST_DATA_BUS_O <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pixel pipeline: capture, lookup, buffer
	logic [7:0]  cap_index;
	logic        cap_blank_n;
	logic [17:0] look_word;
	logic        look_valid;
	logic        cap_valid;
	logic        buf_ready;

	wire [7:0]  masked_index = cap_index & pixel_mask;
	wire [17:0] look_next    = cap_blank_n ? palette[masked_index]
	                                       : {3{BLANK_LEVEL}};

	// A receiver stall holds the pipeline; the source sees PIX_IN_READY low
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cap_index    <= '0;
			cap_blank_n  <= 1'b0;
			cap_valid    <= 1'b0;
			look_word    <= '0;
			look_valid   <= 1'b0;
			PIX_IN_READY <= 1'b0;
		end else begin
			PIX_IN_READY <= buf_ready;
			if (buf_ready) begin
				cap_index   <= PIXEL_INDEX;
				cap_blank_n <= BLANK_N;
				cap_valid   <= 1'b1;
				look_word   <= look_next;
				look_valid  <= cap_valid;
			end
		end
	end

	plk_skid #(.W(WORD_W)) u_skid (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (look_valid & buf_ready),
		.in_ready  (buf_ready),
		.in_data   (look_word),
		.out_valid (PIX_VALID),
		.out_ready (PIX_READY),
		.out_data  ({RED, GREEN, BLUE})
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_color_wr(plk_phase_t ph);
		wr_rise && sel_palette && color_phase_count == ph;
	endsequence

	property p_blank_forces_zero;
		@(posedge SYS_CLK) disable iff (RST) buf_ready && !cap_blank_n |=> look_word == '0;
	endproperty
	a_blank_forces_zero: assert property (p_blank_forces_zero) else $error("blank did not zero colour");

	property p_capture;
		@(posedge SYS_CLK) disable iff (RST)
			!RST && buf_ready |=> cap_index == $past(PIXEL_INDEX) && cap_blank_n == $past(BLANK_N);
	endproperty
	a_capture: assert property (p_capture) else $error("pixel or blank not captured");

	property p_lookup;
		@(posedge SYS_CLK) disable iff (RST)
			buf_ready && cap_blank_n |=> look_word == $past(palette[masked_index]);
	endproperty
	a_lookup: assert property (p_lookup) else $error("lookup word mismatch");

	property p_ptr_write;
		@(posedge SYS_CLK) disable iff (RST)
			wr_rise && sel_ptr_wr |=> palette_pointer == $past(din_s) && color_phase_count == PH_RED;
	endproperty
	a_ptr_write: assert property (p_ptr_write) else $error("pointer write failed");

	property p_blue_write;
		@(posedge SYS_CLK) disable iff (RST)
			s_color_wr(PH_BLUE) |=> palette_pointer == $past(next_pointer)
				&& palette[$past(palette_pointer)] == $past({red_hold, green_hold, din_s[5:0]});
	endproperty
	a_blue_write: assert property (p_blue_write) else $error("blue write did not store");

	property p_red_no_step;
		@(posedge SYS_CLK) disable iff (RST)
			s_color_wr(PH_RED) |=> color_phase_count == PH_GREEN && $stable(palette_pointer);
	endproperty
	a_red_no_step: assert property (p_red_no_step) else $error("red write moved pointer");

	property p_read_ptr;
		@(posedge SYS_CLK) disable iff (RST)
			rd_fall && sel_ptr_rd |=> HOST_DATA_BUS_O == $past(palette_pointer);
	endproperty
	a_read_ptr: assert property (p_read_ptr) else $error("pointer read wrong");

	property p_color_upper_zero;
		@(posedge SYS_CLK) disable iff (RST)
			rd_fall && sel_palette |=> HOST_DATA_BUS_O[7:6] == 2'b00 && rd_is_color;
	endproperty
	a_color_upper_zero: assert property (p_color_upper_zero) else $error("colour read upper bits set");

	property p_read_blue_step;
		@(posedge SYS_CLK) disable iff (RST)
			rd_rise && sel_palette && rd_is_color && is_blue
				|=> palette_pointer == $past(next_pointer) && color_phase_count == PH_RED;
	endproperty
	a_read_blue_step: assert property (p_read_blue_step) else $error("blue read no step");

	property p_drive_only_read;
		@(posedge SYS_CLK) disable iff (RST) HOST_DATA_BUS_OE |-> $past(!rd_n_s && wr_n_s);
	endproperty
	a_drive_only_read: assert property (p_drive_only_read) else $error("bus driven outside read");
endmodule : plk_top
`default_nettype wire

/* tb/plk_host_model.sv */
`default_nettype none
// Host processor on the strobed bus; strobes and select change only after a clock edge
module plk_host_model (
	input  wire logic       clk,
	output logic            wr_n,
	output logic            rd_n,
	output logic [1:0]      rs,
	output logic [7:0]      bus_to_dev,
	input  wire logic [7:0] bus_from_dev,
	input  wire logic       bus_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drv;
	logic [7:0] drv_val;
	// No pull on the bus: released lines show the inverse, never a stale copy
	assign bus_to_dev = bus_oe ? bus_from_dev : (drv ? drv_val : ~drv_val);
	initial begin
		wr_n    = 1'b1;
		rd_n    = 1'b1;
		rs      = 2'h0;
		drv     = 1'b0;
		drv_val = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		@(posedge clk);
		rs      <= sel;
		drv     <= 1'b1;
		drv_val <= d;
		wr_n    <= 1'b0;
		repeat (5) @(posedge clk);
		wr_n <= 1'b1;
		// Data held past the rise, the device syncs it through two stages
		repeat (4) @(posedge clk);
		drv <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [1:0] sel, output logic [7:0] d, output logic oe_seen);
		@(posedge clk);
		rs   <= sel;
		rd_n <= 1'b0;
		repeat (6) @(posedge clk);
		d       = bus_from_dev;
		oe_seen = bus_oe;
		rd_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask : rd
endmodule : plk_host_model
`default_nettype wire

/* tb/palette_lookup_host_port_test.sv */
`default_nettype none
module palette_lookup_host_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	import plk_pkg::*;
	logic       sys_clk, rst, blank_n, pix_ready, pix_in_ready, pix_valid, wr_n, rd_n, oe;
	logic [7:0] pixel_index, bus_i, bus_o, d;
	logic [1:0] rs;
	logic [5:0] red, green, blue;
	logic       o;
	int         bad_count, num_checks;
	logic [7:0] wv [9] = '{8'hD5, 8'hEA, 8'hFF, 8'h41, 8'h82, 8'hC3, 8'h7C, 8'hCF, 8'hF0};
	plk_top plk_top_inst (.SYS_CLK(sys_clk), .RST(rst), .PIXEL_INDEX(pixel_index), .BLANK_N(blank_n),
		.PIX_IN_READY(pix_in_ready), .RED(red), .GREEN(green), .BLUE(blue), .PIX_VALID(pix_valid),
		.PIX_READY(pix_ready), .HOST_WR_N(wr_n), .HOST_RD_N(rd_n), .HOST_REGISTER_SELECT(rs),
		.HOST_DATA_BUS_I(bus_i), .HOST_DATA_BUS_O(bus_o), .HOST_DATA_BUS_OE(oe));
	plk_host_model plk_host_model_inst (.clk(sys_clk), .wr_n(wr_n), .rd_n(rd_n), .rs(rs),
		.bus_to_dev(bus_i), .bus_from_dev(bus_o), .bus_oe(oe));
	always #4 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic hrd(input logic [1:0] sel, input logic [7:0] exp);
		plk_host_model_inst.rd(sel, d, o);
		check({10'h000, d}, {10'h000, exp}, "host read");
		check({17'h0_0000, o}, 18'h0_0001, "bus driven in read");
		check({17'h0_0000, oe}, 18'h0_0000, "bus released after read");
	endtask : hrd
	// Holds one pixel long enough to flush the pipeline, then compares
	task automatic pix(input logic [7:0] idx, input logic bl_n, input logic [17:0] exp);
		@(posedge sys_clk);
		pixel_index <= idx;
		blank_n     <= bl_n;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		check({red, green, blue}, exp, "pixel colour");
		check({17'h0_0000, pix_valid}, 18'h0_0001, "pixel valid");
	endtask : pix
	////////////////////////////////////////////////////////////////
	task automatic t_after_reset;
		hrd(RS_PTR_RD, PTR_RESET);
		hrd(RS_MASK, MASK_RESET);
	endtask : t_after_reset
	// Three entries across the top of the table, upper data bits set on purpose
	task automatic t_write;
		plk_host_model_inst.wr(RS_PTR_WR, 8'hFE);
		foreach (wv[i]) plk_host_model_inst.wr(RS_PALETTE, wv[i]);
		hrd(RS_PTR_RD, 8'h01);
	endtask : t_write
	task automatic t_read;
		logic [7:0] exp [6] = '{8'h01, 8'h02, 8'h03, 8'h3C, 8'h0F, 8'h30};
		plk_host_model_inst.wr(RS_PTR_WR, 8'hFF);
		hrd(RS_PTR_RD, 8'hFF);
		for (int i = 0; i < 6; i++) hrd(RS_PALETTE, exp[i]);
		hrd(RS_PTR_RD, 8'h01);
	endtask : t_read
	task automatic t_pixels;
		pix(8'hFE, 1'b1, {6'h15, 6'h2A, 6'h3F});
		pix(8'hFF, 1'b1, {6'h01, 6'h02, 6'h03});
		pix(8'h00, 1'b1, {6'h3C, 6'h0F, 6'h30});
		pix(8'hFE, 1'b0, {3{BLANK_LEVEL}});
		pix(8'hFF, 1'b1, {6'h01, 6'h02, 6'h03});
	endtask : t_pixels
	task automatic t_mask;
		plk_host_model_inst.wr(RS_MASK, 8'hFE);
		hrd(RS_MASK, 8'hFE);
		pix(8'hFF, 1'b1, {6'h15, 6'h2A, 6'h3F});
		plk_host_model_inst.wr(RS_MASK, 8'h00);
		pix(8'hFF, 1'b1, {6'h3C, 6'h0F, 6'h30});
		plk_host_model_inst.wr(RS_MASK, 8'hFF);
	endtask : t_mask
	// Receiver stalls while the index moves: output holds, input side backs off
	task automatic t_stall;
		pix(8'hFE, 1'b1, {6'h15, 6'h2A, 6'h3F});
		@(posedge sys_clk);
		pix_ready   <= 1'b0;
		pixel_index <= 8'hFF;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check({red, green, blue}, {6'h15, 6'h2A, 6'h3F}, "held colour");
		check({17'h0_0000, pix_in_ready}, 18'h0_0000, "input held off");
		@(posedge sys_clk);
		pix_ready <= 1'b1;
		pix(8'hFF, 1'b1, {6'h01, 6'h02, 6'h03});
	endtask : t_stall
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk     = 1'b0;
		rst         = 1'b1;
		pixel_index = 8'h00;
		// Blanked until the palette is loaded, so no unwritten entry is looked up
		blank_n     = 1'b0;
		pix_ready   = 1'b1;
		bad_count   = 0;
		num_checks  = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		t_after_reset();
		t_write();
		t_read();
		t_pixels();
		t_mask();
		t_stall();
		tally_and_finish();
	end
	// About 410 cycles of work expected; far beyond that means a hang
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
endmodule : palette_lookup_host_port_test
`default_nettype wire
